// >>> src/wwd_consts.svh
// Purpose: constants for the windowed system watchdog
// Assumes: 50 MHz core clock, oscillator ticks arrive as one-cycle enables
// Notes: register offsets are word addresses on the plain register port
// Function
// - 12-bit down-counter clocked through a prescaler chosen by a 3-bit setting.
// - underflow without prior reload raises the system reset.
// - reload while count exceeds delta raises the system reset.
// - optional halt of the counter while the processor is in debug mode.
// - while write protection is on, configuration writes are ignored.
// - counter tick comes from internal or external low-speed oscillator, as selected.
`ifndef WWD_CONSTS_SVH
`define WWD_CONSTS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define WWD_OFS_CTRL 4'h0
`define WWD_OFS_MODE 4'h1
`define WWD_OFS_RELOAD 4'h2
`define WWD_OFS_DELTA 4'h3
`define WWD_OFS_PROT 4'h4
`define WWD_OFS_COUNT 4'h5
`define WWD_OFS_STATUS 4'h6
// ----------------------------------------
// field values and resets
// ----------------------------------------
`define WWD_KEY_RELOAD 16'h5FA0
`define WWD_KEY_UNLOCK 16'h35CA
`define WWD_RST_RELOAD 12'hFFF
`define WWD_RST_DELTA 12'hFFF
`define WWD_RST_PRESC 3'h0
`define WWD_RESET_HOLD_NS 1000
`define WWD_CLK_NS 20
`define WWD_RESET_HOLD_CYC ((`WWD_RESET_HOLD_NS + `WWD_CLK_NS - 1) / `WWD_CLK_NS)
`endif

// >>> src/wwd_pkg.sv
// Purpose: types for the windowed system watchdog
// Assumes: nothing beyond the constants header
// Notes: mode word layout shared by core and register logic
package wwd_pkg;
   typedef struct packed {
      logic enable;
      logic debug_halt;
      logic use_external;
      logic [2:0] presc_sel;
   } wwd_mode_s;
   typedef enum logic [1:0] {WWD_IDLE, WWD_RUN, WWD_FIRE} wwd_state_e;
endpackage

// >>> src/wwd_prescaler.sv
// Purpose: divide the selected oscillator tick by 2^sel
// Assumes: tick inputs are one-cycle pulses in the core clock domain
// Notes: restart re-aligns the divider so a reload starts a full period, except that a hit in the restart cycle still pulses tick_out
`timescale 1ns/1ps
`include "wwd_consts.svh"
module wwd_prescaler
   import wwd_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic tick_int,
   input wire logic tick_ext,
   input wire logic use_ext,
   input wire logic [2:0] sel,
   input wire logic run,
   input wire logic restart,
   output logic tick_out
);
   logic [6:0] div;
   wire src_tick = use_ext ? tick_ext : tick_int;
   wire [6:0] mask = 7'((8'h01 << sel) - 8'h01);
   wire hit = src_tick && run && ((div & mask) == mask);
   // ----------------------------------------
   // divider
   // ----------------------------------------
   // divider counter, cleared on restart
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div <= 7'h00;
         tick_out <= 1'b0;
      end else begin
         tick_out <= hit;
         if (restart)
            div <= 7'h00;
         else if (src_tick && run)
            div <= 7'(div + 7'h01);
      end
   end
endmodule

// >>> src/wwd_counter.sv
// Purpose: 12-bit down-counter with window check
// Assumes: tick is a one-cycle enable from the prescaler
// Notes: underflow means stepping below zero
`timescale 1ns/1ps
`include "wwd_consts.svh"
module wwd_counter
   import wwd_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic tick,
   input wire logic load,
   input wire logic [11:0] reload_val,
   input wire logic [11:0] delta_val,
   output logic [11:0] count,
   output logic underflow,
   output logic early
);
   // early reload: count still above delta
   assign early = load && (count > delta_val);
   // count update, a reload wins over a tick in the same cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= `WWD_RST_RELOAD;
         underflow <= 1'b0;
      end else begin
         underflow <= tick && !load && (count == 12'h000);
         if (load)
            count <= reload_val;
         else if (tick && count != 12'h000)
            count <= 12'(count - 12'h001);
      end
   end
endmodule

// >>> src/wwd_top.sv
// Purpose: windowed system watchdog with register port
// Assumes: single core clock; oscillator ticks are synchronous enables
// Notes: once enabled the watchdog cannot be turned off until system reset
`timescale 1ns/1ps
`include "wwd_consts.svh"
module wwd_top
   import wwd_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic ARST_N,
   input wire logic [3:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic LOW_SPEED_INTERNAL_OSC_TICK,
   input wire logic LOW_SPEED_EXTERNAL_OSC_TICK,
   input wire logic DEBUG_MODE,
   output logic SYS_RESET_N
);
   // ----------------------------------------
   // register state
   // ----------------------------------------
   wwd_mode_s mode;
   logic [11:0] reload_val;
   logic [11:0] delta_val;
   logic locked;
   logic cause_under;
   logic cause_early;
   wwd_state_e state;
   logic [7:0] hold_cnt;
   logic [11:0] count;
   logic tick;
   logic underflow;
   logic early;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   // write decode; reload key works even while locked
   wire wr_ctrl = WR && (ADDR == `WWD_OFS_CTRL);
   wire do_reload = wr_ctrl && (WDATA[15:0] == `WWD_KEY_RELOAD) && mode.enable;
   wire cfg_ok = !locked;
   wire wr_mode = WR && (ADDR == `WWD_OFS_MODE) && cfg_ok;
   wire wr_reload = WR && (ADDR == `WWD_OFS_RELOAD) && cfg_ok;
   wire wr_delta = WR && (ADDR == `WWD_OFS_DELTA) && cfg_ok;
   wire wr_prot = WR && (ADDR == `WWD_OFS_PROT);
   // halt in debug only when the option is set
   wire run = mode.enable && !(mode.debug_halt && DEBUG_MODE);
   wire fire_early = early && state == WWD_RUN;
   wire fire_under = underflow && state == WWD_RUN;
   wire fire = fire_early || fire_under;
   wire valid_load = do_reload && !early;
   wire [31:0] rd_mux =
      (ADDR == `WWD_OFS_MODE) ? {26'h000_0000, mode} :
      (ADDR == `WWD_OFS_RELOAD) ? {20'h0_0000, reload_val} :
      (ADDR == `WWD_OFS_DELTA) ? {20'h0_0000, delta_val} :
      (ADDR == `WWD_OFS_PROT) ? {31'h0000_0000, locked} :
      (ADDR == `WWD_OFS_COUNT) ? {20'h0_0000, count} :
      (ADDR == `WWD_OFS_STATUS) ? {30'h0000_0000, cause_early, cause_under} :
      32'h0000_0000;

   // ----------------------------------------
   // submodules
   // ----------------------------------------
   // the prescaler restarts on a reload that is not early; the first step comes a full period later, or next cycle if a hit falls in the reload cycle
   wwd_prescaler u_presc (
      .clk(CORE_CLK),
      .arst_n(ARST_N),
      .tick_int(LOW_SPEED_INTERNAL_OSC_TICK),
      .tick_ext(LOW_SPEED_EXTERNAL_OSC_TICK),
      .use_ext(mode.use_external),
      .sel(mode.presc_sel),
      .run(run),
      .restart(valid_load),
      .tick_out(tick)
   );
   wwd_counter u_cnt (
      .clk(CORE_CLK),
      .arst_n(ARST_N),
      .tick(tick && run),
      .load(do_reload),
      .reload_val(reload_val),
      .delta_val(delta_val),
      .count(count),
      .underflow(underflow),
      .early(early)
   );

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   // enable is sticky: software may set it but never clear it
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mode <= '{enable: 1'b0, debug_halt: 1'b0, use_external: 1'b0,
                   presc_sel: `WWD_RST_PRESC};
         reload_val <= `WWD_RST_RELOAD;
         delta_val <= `WWD_RST_DELTA;
      end else begin
         if (wr_mode) begin
            mode.enable <= mode.enable | WDATA[5];
            mode.debug_halt <= WDATA[4];
            mode.use_external <= WDATA[3];
            mode.presc_sel <= WDATA[2:0];
         end
         if (wr_reload)
            reload_val <= WDATA[11:0];
         if (wr_delta)
            delta_val <= WDATA[11:0];
      end
   end

   // protection: unlock key clears, any other write relocks
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N)
         locked <= 1'b0;
      else if (wr_prot)
         locked <= (WDATA[15:0] != `WWD_KEY_UNLOCK);
   end

   // ----------------------------------------
   // reset sequencer
   // ----------------------------------------
   // reset pulse stretched so slow logic downstream sees it; causes survive it
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= WWD_IDLE;
         hold_cnt <= 8'h00;
         SYS_RESET_N <= 1'b1;
         cause_under <= 1'b0;
         cause_early <= 1'b0;
      end else begin
         unique case (state)
            WWD_IDLE: begin
               if (mode.enable)
                  state <= WWD_RUN;
            end
            WWD_RUN: begin
               if (fire) begin
                  state <= WWD_FIRE;
                  hold_cnt <= 8'(`WWD_RESET_HOLD_CYC - 1);
                  SYS_RESET_N <= 1'b0;
                  cause_under <= fire_under;
                  cause_early <= fire_early;
               end
            end
            WWD_FIRE: begin
               if (hold_cnt == 8'h00)
                  SYS_RESET_N <= 1'b1;
               else
                  hold_cnt <= 8'(hold_cnt - 8'h01);
            end
         endcase
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N)
         RDATA <= 32'h0000_0000;
      else
         RDATA <= RD ? rd_mux : 32'h0000_0000;
   end
endmodule

// >>> sim/wwd_monitor.sv
// Purpose: port checks for the windowed watchdog
// Assumes: one clock, async active-low reset
// Notes: lock and reload are shadowed from bus writes
`timescale 1ns/1ps
`include "wwd_consts.svh"
module wwd_monitor (
   input wire logic CORE_CLK,
   input wire logic ARST_N,
   input wire logic [3:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic LOW_SPEED_INTERNAL_OSC_TICK,
   input wire logic LOW_SPEED_EXTERNAL_OSC_TICK,
   input wire logic SYS_RESET_N
);
   // ---------------
   // helper state
   // ---------------
   logic [6:0] low_cnt;
   logic [2:0] age;
   logic locked;
   logic fired;
   logic [11:0] rld;
   wire key_wr = WR && ADDR == 4'h0 && WDATA[15:0] == `WWD_KEY_RELOAD;
   wire tck = LOW_SPEED_INTERNAL_OSC_TICK || LOW_SPEED_EXTERNAL_OSC_TICK;
   // age saturates so a stale tick can never excuse a reset
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         low_cnt <= 7'h00;
         age <= 3'h7;
         locked <= 1'b0;
         fired <= 1'b0;
         rld <= `WWD_RST_RELOAD;
      end else begin
         low_cnt <= SYS_RESET_N ? 7'h00 : low_cnt + 7'h01;
         age <= tck ? 3'h0 : (age == 3'h7 ? age : age + 3'h1);
         locked <= (WR && ADDR == 4'h4) ? WDATA[15:0] != `WWD_KEY_UNLOCK : locked;
         fired <= fired || !SYS_RESET_N;
         rld <= (WR && ADDR == 4'h2 && !locked) ? WDATA[11:0] : rld;
      end
   end
   // ---------------
   // properties
   // ---------------
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!ARST_N);
   property p_hold; $rose(SYS_RESET_N) |-> low_cnt == `WWD_RESET_HOLD_CYC; endproperty
   property p_cause; $fell(SYS_RESET_N) |-> $past(key_wr) || age <= 3'h4; endproperty
   property p_once; $fell(SYS_RESET_N) |-> !fired; endproperty
   property p_quiet; $past(!ARST_N) |-> SYS_RESET_N; endproperty
   property p_lock; RD && ADDR == 4'h4 |=> RDATA[0] == locked; endproperty
   property p_reload;
      key_wr ##1 !tck ##1 (RD && ADDR == 4'h5 && SYS_RESET_N) |=> RDATA[11:0] == rld;
   endproperty
   property p_status; RD && ADDR == 4'h6 |=> RDATA[31:2] == '0; endproperty
   property p_unmap; RD && ADDR > 4'h6 |=> RDATA == '0; endproperty
   a_hold: assert property (p_hold) else $error("reset pulse length wrong");
   a_cause: assert property (p_cause) else $error("reset without cause");
   a_once: assert property (p_once) else $error("second reset pulse");
   a_quiet: assert property (p_quiet) else $error("reset out after release");
   a_lock: assert property (p_lock) else $error("lock flag wrong");
   a_reload: assert property (p_reload) else $error("reload value not loaded");
   a_status: assert property (p_status) else $error("status spare bits set");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   c_early: cover property (key_wr ##1 !SYS_RESET_N);
   c_end: cover property ($rose(SYS_RESET_N));
   c_lock: cover property (RD && ADDR == 4'h4 ##1 RDATA[0]);
endmodule
bind wwd_top wwd_monitor u_mon (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SYS_RESET_N(SYS_RESET_N),
   .LOW_SPEED_INTERNAL_OSC_TICK(LOW_SPEED_INTERNAL_OSC_TICK),
   .LOW_SPEED_EXTERNAL_OSC_TICK(LOW_SPEED_EXTERNAL_OSC_TICK));

// >>> sim/test_windowed_watchdog_timer.sv
// Purpose: directed register test of the windowed watchdog
// Assumes: oscillator ticks are one-cycle enables from the bench
// Notes: counts are small, nothing is shortened
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
   $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module test_windowed_watchdog_timer;
   logic clk = 0, arst_n = 0, wr = 0, rd = 0, t_int = 0, t_ext = 0, dbg = 0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic sys_rst_n;
   int miscompares = 0;
   int check_count = 0;
   wwd_top uut (.CORE_CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .LOW_SPEED_INTERNAL_OSC_TICK(t_int),
      .LOW_SPEED_EXTERNAL_OSC_TICK(t_ext), .DEBUG_MODE(dbg), .SYS_RESET_N(sys_rst_n));
   // ---------------
   // bus and tick tasks
   // ---------------
   initial begin
      forever #10 clk = ~clk;
   end
   // a spare cycle after each access keeps strobes from being set twice per step
   task automatic w(input logic [3:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= {16'h0000, d};
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic r(input logic [3:0] a, input logic [11:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 `CHK(rdata, {20'h0_0000, e})
      @(posedge clk);
   endtask
   task automatic tk(input logic ext, input int n);
      repeat (n) begin
         t_int <= !ext;
         t_ext <= ext;
         @(posedge clk);
         t_int <= 1'b0;
         t_ext <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
   task automatic rst_is(input logic e);
      #1 `CHK(sys_rst_n, e)
      @(posedge clk);
   endtask
   task automatic summarize;
      if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ---------------
   // sequence
   // ---------------
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      summarize();
   end
   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      r(4'h2, 12'hFFF);
      r(4'h7, 12'h000);
      w(4'h4, 16'h0000);
      r(4'h4, 12'h001);
      w(4'h3, 16'h0001);
      r(4'h3, 12'hFFF);
      w(4'h1, 16'h0020);
      r(4'h1, 12'h000);
      w(4'h2, 16'h0010);
      r(4'h2, 12'hFFF);
      w(4'h4, 16'h35CA);
      r(4'h4, 12'h000);
      w(4'h2, 16'h0010);
      w(4'h1, 16'h0021);
      w(4'h0, 16'h5FA0);
      r(4'h5, 12'h010);
      w(4'h3, 16'h0008);
      r(4'h3, 12'h008);
      tk(1'b0, 4);
      r(4'h5, 12'h00E);
      w(4'h1, 16'h0030);
      r(4'h1, 12'h030);
      dbg <= 1'b1;
      tk(1'b0, 3);
      r(4'h5, 12'h00E);
      dbg <= 1'b0;
      tk(1'b0, 1);
      r(4'h5, 12'h00D);
      w(4'h1, 16'h0038);
      tk(1'b0, 2);
      tk(1'b1, 2);
      r(4'h5, 12'h00B);
      w(4'h0, 16'h5FA0);
      rst_is(1'b0);
      r(4'h6, 12'h002);
      repeat (60) @(posedge clk);
      rst_is(1'b1);
      arst_n <= 1'b0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      w(4'h2, 16'h0003);
      w(4'h1, 16'h0022);
      w(4'h0, 16'h5FA0);
      tk(1'b0, 6);
      r(4'h5, 12'h002);
      w(4'h0, 16'h5FA0);
      r(4'h5, 12'h003);
      tk(1'b0, 3);
      r(4'h5, 12'h003);
      rst_is(1'b1);
      tk(1'b0, 13);
      rst_is(1'b0);
      r(4'h6, 12'h001);
      summarize();
   end
endmodule
